// file: dv/smdd_link_sva.sv
// Checker on the table read link signals
// Assumes the testbench places it beside the link interface
`timescale 1ns/1ps
module smdd_link_sva (
  // Link clock, reset and signals
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  localparam logic [31:0] det1_w = 32'h803007FC;
  localparam logic [31:0] det2_w = 32'h043035FD;
  localparam logic [31:0] map_w = 32'hFF0100FE;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ****************
  // Link properties
  // ****************
  property p_ans;
    rd_req |=> rd_valid;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_quiet;
    !rd_req |=> !rd_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  // Answer byte moves only with a valid strobe, or when reset clears it
  property p_hold;
    !rd_valid && !$past(sys_rst_i) |-> $stable(rd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_det1;
    rd_req && rd_addr[7:2] == 6'h10 |=> rd_data == det1_w[8*$past(rd_addr[1:0]) +: 8];
  endproperty
  a_det1: assert property (p_det1) else $error("bad first descriptor");
  property p_addr;
    rd_req && rd_addr[7:2] == 6'h11 |=> rd_data == 8'hFF;
  endproperty
  a_addr: assert property (p_addr) else $error("bad address field");
  property p_det2;
    rd_req && rd_addr[7:2] == 6'h12 |=> rd_data == det2_w[8*$past(rd_addr[1:0]) +: 8];
  endproperty
  a_det2: assert property (p_det2) else $error("bad second descriptor");
  property p_map;
    rd_req && rd_addr[7:2] == 6'h14 |=> rd_data == map_w[8*$past(rd_addr[1:0]) +: 8];
  endproperty
  a_map: assert property (p_map) else $error("bad map header");
  // Low byte, instruction byte and command field byte of both descriptors
  property p_type;
    rd_req && rd_addr[7:4] == 4'h4 && rd_addr[2:0] == 3'h0
      |=> rd_data == {6'h3F, 1'b0, $past(rd_addr[3])};
  endproperty
  a_type: assert property (p_type) else $error("bad type bits");
  property p_cmdfld;
    rd_req && rd_addr[7:4] == 4'h4 && rd_addr[2:0] == 3'h2 |=> rd_data == 8'h30;
  endproperty
  a_cmdfld: assert property (p_cmdfld) else $error("bad length byte");
  property p_instr;
    rd_req && rd_addr[7:4] == 4'h4 && rd_addr[2:0] == 3'h1
      |=> rd_data == ($past(rd_addr[3]) ? 8'h35 : 8'h07);
  endproperty
  a_instr: assert property (p_instr) else $error("bad instruction");
  c_det1: cover property (rd_req && rd_addr == 8'h40);
  c_det2: cover property (rd_req && rd_addr == 8'h48);
  c_last: cover property (rd_req && rd_addr == 8'h4B);
  c_map: cover property (rd_req && rd_addr == 8'h53);
endmodule

// file: dv/tb.sv
// Testbench joining the table and host ends over the read link
// Assumes the host waits for each detection byte after its command
`timescale 1ns/1ps
module tb;
  import smdd_pkg::*;
  logic ref_clk_i, sys_rst_i, start_i, det_valid_i, cmd_v, done, eo, psl, match, bad;
  smdd_byte_t det_data_i, instr;
  logic [1:0] alen, id;
  logic [3:0] lat;
  int errors, check_count, cyc;
  smdd_if lnk ();
  smdd_table i_smdd_table (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk));
  smdd_host i_smdd_host (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk),
    .start_i(start_i), .cmd_valid_o(cmd_v), .cmd_instr_o(instr), .cmd_addr_len_o(alen),
    .cmd_latency_o(lat), .det_valid_i(det_valid_i), .det_data_i(det_data_i), .done_o(done),
    .erase_opcode_option_o(eo), .param_sector_location_o(psl), .config_id_o(id),
    .id_match_o(match), .bad_table_o(bad));
  smdd_link_sva i_smdd_link_sva (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .rd_req(lnk.rd_req), .rd_addr(lnk.rd_addr), .rd_valid(lnk.rd_valid), .rd_data(lnk.rd_data));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge ref_clk_i);
    #2;
  endtask
  // Bounded wait for the command strobe (which 0) or for done (which 1)
  task automatic wait_hi(input bit which);
    int n;
    n = 0;
    while ((which ? done : cmd_v) !== 1'b1 && n < 200)
    begin
      step();
      n++;
    end
    chk(8'(n < 200), 8'h01);
  endtask
  // Detection byte returned a cycle after the command
  task automatic answer(input smdd_byte_t d);
    step();
    det_valid_i = 1'b1;
    det_data_i = d;
    step();
    det_valid_i = 1'b0;
    det_data_i = ~d;
  endtask
  // Whole parse with the two detection bytes given
  task automatic parse(input smdd_byte_t d1, input smdd_byte_t d2);
    start_i = 1'b1;
    wait_hi(1'b0);
    chk(instr, 8'h07);
    chk({2'h0, alen, lat}, 8'h00);
    answer(d1);
    wait_hi(1'b0);
    chk(instr, 8'h35);
    chk({2'h0, alen, lat}, 8'h00);
    answer(d2);
    wait_hi(1'b1);
    chk({eo, psl, bad, 3'h0, id}, {d1[7], d2[2], 4'h0, d1[7], d2[2]});
    chk({7'h0, match}, {7'h0, d1[7] == 1'b0 && d2[2] == 1'b0});
    start_i = 1'b0;
    step();
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_stray();
    start_i = 1'b1;
    det_valid_i = 1'b1;
    det_data_i = 8'hFF;
    step();
    det_valid_i = 1'b0;
    parse(8'h00, 8'h00);
  endtask
  task automatic t_zero_id();
    parse(8'h7F, 8'hFB);
  endtask
  // Reset in the middle of a parse clears every result, then a parse runs
  task automatic t_mid_reset();
    start_i = 1'b1;
    wait_hi(1'b0);
    sys_rst_i = 1'b1;
    step();
    sys_rst_i = 1'b0;
    start_i = 1'b0;
    chk({done, cmd_v, bad, match, id, eo, psl}, 8'h00);
    chk(lnk.rd_addr, 8'h00);
    parse(8'h00, 8'h04);
  endtask
  task automatic t_opt_only();
    parse(8'h80, 8'h00);
  endtask
  task automatic t_loc_only();
    parse(8'h00, 8'h04);
  endtask
  task automatic t_both();
    parse(8'hFF, 8'hFF);
  endtask
  task automatic close_out();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // Main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    start_i = 1'b0;
    det_valid_i = 1'b0;
    det_data_i = 8'h00;
    repeat (12) @(posedge ref_clk_i);
    #2;
    sys_rst_i = 1'b0;
    chk({done, cmd_v, bad, match, id, eo, psl}, 8'h00);
    t_stray();
    t_zero_id();
    t_mid_reset();
    t_opt_only();
    t_loc_only();
    t_both();
    close_out();
  end
  // Hang guard
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge ref_clk_i);
      cyc++;
      if (cyc == 3000)
      begin
        errors++;
        close_out();
      end
    end
  end
endmodule

// file: hw/smdd_host.sv
// Host that reads the detection descriptors and the first map header
// Every command descriptor is followed by its address field dword.
// Assumes the table end answers one cycle after each request and that
// the user returns each detection byte through det_valid_i/det_data_i.
`timescale 1ns/1ps
`include "smdd_regs.svh"
module smdd_host (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Link
  smdd_if.host_end lnk,
  // User control
  input wire logic start_i,
  // Detection command issue
  output logic cmd_valid_o,
  output smdd_pkg::smdd_byte_t cmd_instr_o,
  output logic [1:0] cmd_addr_len_o,
  output logic [3:0] cmd_latency_o,
  input wire logic det_valid_i,
  input wire smdd_pkg::smdd_byte_t det_data_i,
  // Results
  output logic done_o,
  output logic erase_opcode_option_o,
  output logic param_sector_location_o,
  output logic [1:0] config_id_o,
  output logic id_match_o,
  output logic bad_table_o
);
  import smdd_pkg::*;
  typedef enum {S_IDLE, S_REQ, S_WAIT, S_CMD, S_RESP, S_DONE} smdd_state_t;
  smdd_state_t state;
  smdd_state_t next_state;
  logic [7:0] addr;
  logic [7:0] next_addr;
  smdd_word_t word;
  smdd_word_t next_word;
  smdd_word_t desc;
  smdd_word_t next_desc;
  logic [1:0] id;
  logic [1:0] next_id;
  logic done;
  logic next_done;
  logic bad;
  logic next_bad;
  logic match;
  logic next_match;
  logic [7:0] masked;
  logic addr_phase;
  logic next_addr_phase;
  smdd_word_t fill_word;
  logic fmt_ok;
  // ****************************************
  // Descriptor assembly and format
  // ****************************************
  // Shifts the answer byte in at the top so the low offset ends as bits 7:0;
  // a detection descriptor must be a command type with all reserved bits set
  always_comb
  begin
    fill_word = {lnk.rd_data, word[31:8]};
    fmt_ok = 1'b1;
    if (fill_word[`SMDD_TYPE_BIT])
      fmt_ok = 1'b0;
    if (!(&fill_word[`SMDD_RSVB_HI:`SMDD_RSVB_LO]))
      fmt_ok = 1'b0;
    if (!(&fill_word[`SMDD_RSVA_HI:`SMDD_RSVA_LO]))
      fmt_ok = 1'b0;
  end
  // ****************************************
  // Sequencer
  // ****************************************
  // Reads each dword bytewise, issues commands, then checks the map header
  always_comb
  begin
    next_state = state;
    next_addr = addr;
    next_addr_phase = addr_phase;
    next_word = word;
    next_desc = desc;
    next_id = id;
    next_done = done;
    next_bad = bad;
    next_match = match;
    masked = det_data_i & desc[`SMDD_MASK_HI:`SMDD_MASK_LO];
    unique case (state)
      S_IDLE:
      begin
        if (start_i)
        begin
          next_addr = `SMDD_OFS_DET1;
          next_id = 2'b00;
          next_done = 1'b0;
          next_bad = 1'b0;
          next_match = 1'b0;
          next_addr_phase = 1'b0;
          next_state = S_REQ;
        end
      end
      S_REQ:
        next_state = S_WAIT;
      S_WAIT:
      begin
        if (lnk.rd_valid)
        begin
          next_word = fill_word;
          if (addr[1:0] != 2'b11)
          begin
            next_addr = addr + 8'h01;
            next_state = S_REQ;
          end
          else if (addr == `SMDD_OFS_MAP + 8'h03)
          begin
            // Compare against the map header identifier
            next_match = fill_word[`SMDD_CFGID_HI:`SMDD_CFGID_LO] == {6'h00, id};
            next_done = 1'b1;
            next_state = S_DONE;
          end
          else if (addr_phase)
          begin
            // Address field after each command: all ones means no address
            next_bad = bad | (fill_word != {4{`SMDD_FILL_BYTE}});
            next_addr_phase = 1'b0;
            // The end marker hands over to the map header instead
            if (desc[`SMDD_END_BIT])
              next_addr = `SMDD_OFS_MAP;
            else
              next_addr = addr + 8'h01;
            next_state = S_REQ;
          end
          else
          begin
            // Keep the descriptor for the command fields and the end marker
            next_desc = fill_word;
            if (!fmt_ok)
              next_bad = 1'b1;
            next_state = S_CMD;
          end
        end
      end
      S_CMD:
        next_state = S_RESP;
      S_RESP:
      begin
        if (det_valid_i)
        begin
          next_id = {id[0], |masked};
          // The command's address field dword comes next
          next_addr = addr + 8'h01;
          next_addr_phase = 1'b1;
          next_state = S_REQ;
        end
      end
      S_DONE:
        if (!start_i)
          next_state = S_IDLE;
    endcase
  end
  // Registers sequencer state
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= S_IDLE;
      addr <= `SMDD_RST_BYTE;
      addr_phase <= 1'b0;
      word <= `SMDD_RST_WORD;
      desc <= `SMDD_RST_WORD;
      id <= 2'b00;
      done <= 1'b0;
      bad <= 1'b0;
      match <= 1'b0;
    end
    else
    begin
      state <= next_state;
      addr <= next_addr;
      addr_phase <= next_addr_phase;
      word <= next_word;
      desc <= next_desc;
      id <= next_id;
      done <= next_done;
      bad <= next_bad;
      match <= next_match;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign lnk.rd_req = (state == S_REQ);
  assign lnk.rd_addr = addr;
  assign cmd_valid_o = (state == S_CMD);
  assign cmd_instr_o = desc[`SMDD_INSTR_HI:`SMDD_INSTR_LO];
  assign cmd_addr_len_o = desc[`SMDD_ALEN_HI:`SMDD_ALEN_LO];
  assign cmd_latency_o = desc[`SMDD_LAT_HI:`SMDD_LAT_LO];
  assign done_o = done;
  assign erase_opcode_option_o = id[1];
  assign param_sector_location_o = id[0];
  assign config_id_o = id;
  assign id_match_o = match;
  assign bad_table_o = bad;
endmodule

// file: hw/smdd_if.sv
// Read link between the parameter table and the host that parses it
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface smdd_if;
  logic rd_req;
  logic [7:0] rd_addr;
  logic rd_valid;
  logic [7:0] rd_data;
  modport table_end (input rd_req, input rd_addr, output rd_valid, output rd_data);
  modport host_end (output rd_req, output rd_addr, input rd_valid, input rd_data);
endinterface

// file: hw/smdd_pkg.sv
// Types shared by both ends of the detection descriptor link
// Assumes smdd_regs.svh for numeric constants
package smdd_pkg;
  typedef logic [7:0] smdd_byte_t;
  typedef logic [31:0] smdd_word_t;
endpackage

// file: hw/smdd_regs.svh
// Constants for the sector-map detection descriptor table
// Assumes byte offsets relative to the sector map parameter table start
`ifndef SMDD_REGS_SVH
`define SMDD_REGS_SVH
// ****************************************
// Table offsets
// ****************************************
`define SMDD_OFS_DET1 8'h40
`define SMDD_OFS_ADDR 8'h44
`define SMDD_OFS_DET2 8'h48
`define SMDD_OFS_MAP 8'h50
`define SMDD_OFS_LAST 8'h53
// ****************************************
// Descriptor contents
// ****************************************
`define SMDD_DET1_WORD 32'h803007FC
`define SMDD_ADDR_WORD 32'hFFFFFFFF
`define SMDD_DET2_WORD 32'h043035FD
`define SMDD_MAP_WORD 32'hFF0100FE
`define SMDD_FILL_BYTE 8'hFF
// ****************************************
// Descriptor field positions
// ****************************************
`define SMDD_MASK_HI 31
`define SMDD_MASK_LO 24
`define SMDD_ALEN_HI 23
`define SMDD_ALEN_LO 22
`define SMDD_LAT_HI 19
`define SMDD_LAT_LO 16
`define SMDD_INSTR_HI 15
`define SMDD_INSTR_LO 8
`define SMDD_TYPE_BIT 1
`define SMDD_END_BIT 0
`define SMDD_CFGID_HI 15
`define SMDD_CFGID_LO 8
`define SMDD_RSVA_HI 21
`define SMDD_RSVA_LO 20
`define SMDD_RSVB_HI 7
`define SMDD_RSVB_LO 2
// ****************************************
// Reset values
// ****************************************
`define SMDD_RST_BYTE 8'h00
`define SMDD_RST_WORD 32'h00000000
`endif

// file: hw/smdd_table.sv
// Read-only detection descriptor table, answers one byte per request
// Assumes requests are single-cycle pulses on the shared clock
`timescale 1ns/1ps
`include "smdd_regs.svh"
module smdd_table (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Link
  smdd_if.table_end lnk
);
  import smdd_pkg::*;
  smdd_pkg::smdd_byte_t data_q;
  smdd_pkg::smdd_byte_t next_data;
  logic valid_q;
  logic next_valid;
  smdd_pkg::smdd_word_t word;
  // ****************************************
  // Byte lookup
  // ****************************************
  // Picks the dword, then the byte lane, least significant byte first
  always_comb
  begin
    word = {4{`SMDD_FILL_BYTE}};
    if (lnk.rd_addr[7:2] == 6'(`SMDD_OFS_DET1 >> 2))
      word = `SMDD_DET1_WORD;
    else if (lnk.rd_addr[7:2] == 6'(`SMDD_OFS_ADDR >> 2))
      word = `SMDD_ADDR_WORD;
    else if (lnk.rd_addr[7:2] == 6'(`SMDD_OFS_DET2 >> 2))
      word = `SMDD_DET2_WORD;
    else if (lnk.rd_addr[7:2] == 6'(`SMDD_OFS_MAP >> 2))
      word = `SMDD_MAP_WORD;
    next_valid = lnk.rd_req;
    next_data = data_q;
    if (lnk.rd_req)
      next_data = word[lnk.rd_addr[1:0]*8 +: 8];
  end
  // Registers the answer one cycle after the request
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      data_q <= `SMDD_RST_BYTE;
      valid_q <= 1'b0;
    end
    else
    begin
      data_q <= next_data;
      valid_q <= next_valid;
    end
  end
  assign lnk.rd_valid = valid_q;
  assign lnk.rd_data = data_q;
endmodule
